// file: hw/dbc_arbiter.sv
// channel arbiter: fixed or rotating priority, one-hot grant
// assumes requests and rotate select come from the same clock domain
`timescale 1ns/1ps
`default_nettype none

module dbc_arbiter #(
	parameter int N = 8
) (
	input  wire logic         clk_i,
	input  wire logic         rst_ni,
	input  wire logic [N-1:0] req_i,
	input  wire logic         rotate_i,
	output logic      [N-1:0] grant_o
);

	localparam int IW = $clog2(N);

	if (N < 2)
	begin : g_bad_n
		$error("dbc_arbiter needs at least two requesters");
	end

	logic [IW-1:0] last_q;
	logic [IW-1:0] last_d;

	// ======================================================
	// search from the slot after the last winner when rotating
	always_comb
	begin
		int  idx;
		logic found;
		idx     = 0;
		found   = 1'b0;
		grant_o = '0;
		last_d  = last_q;
		for (int k = 0; k < N; k++)
		begin
			idx = rotate_i ? (int'(last_q) + 1 + k) % N : k;
			if (!found && req_i[idx])
			begin
				grant_o[idx] = 1'b1;
				last_d       = IW'(idx);
				found        = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_ni)
	begin
		if (!rst_ni)
			last_q <= '0;
		else
			last_q <= last_d;
	end

endmodule // dbc_arbiter

`default_nettype wire

// file: hw/dbc_ctrl.sv
// buffer-process control for an eight-channel dma engine
// assumes a byte-wide register port on clk_i; request and end pins are asynchronous
`timescale 1ns/1ps
`default_nettype none

module dbc_ctrl
	import dbc_pkg::*;
(
	input  wire logic                       clk_i,
	input  wire logic                       resetn_i,
	input  wire logic [dbc_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [dbc_pkg::DATA_W-1:0] wdata_i,
	input  wire logic                       wr_i,
	input  wire logic                       rd_i,
	output logic      [dbc_pkg::DATA_W-1:0] rdata_o,
	input  wire logic [dbc_pkg::NUM_CH-1:0] channel_request_line_i,
	input  wire logic                       end_of_process_input_i,
	output logic      [dbc_pkg::NUM_CH-1:0] grant_o,
	output logic                            chain_reload_irq_o,
	output logic                            tc_irq_o
);

	// ======================================================
	// reset release and input synchronisers
	logic                rst_meta_q;
	logic                rst_n;
	logic [NUM_CH-1:0]   req_meta_q;
	logic [NUM_CH-1:0]   req_s_q;
	logic                eop_meta_q;
	logic                eop_s_q;

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			req_meta_q <= '0;
			req_s_q    <= '0;
			eop_meta_q <= 1'b0;
			eop_s_q    <= 1'b0;
		end
		else
		begin
			req_meta_q <= channel_request_line_i;
			req_s_q    <= req_meta_q;
			eop_meta_q <= end_of_process_input_i;
			eop_s_q    <= eop_meta_q;
		end
	end

	// ======================================================
	// global registers and decode
	logic [7:0]        cmd1_q;
	logic [7:0]        cmd2_q;
	logic [2:0]        chsel_q;
	logic              bp_q;
	logic              tc_irq_q;
	logic [NUM_CH-1:0] grant_q;
	logic [NUM_CH-1:0] grant_d;
	logic [NUM_CH-1:0] elig;
	logic [NUM_CH-1:0] done_v;
	logic [NUM_CH-1:0] swdone_v;
	logic [NUM_CH-1:0] mask_v;
	logic [NUM_CH-1:0] swreq_v;
	logic [NUM_CH-1:0] pend_v;
	logic [NUM_CH-1:0] tc_v;
	logic [NUM_CH-1:0] req_act;
	logic [NUM_CH-1:0] grp_en;
	logic              eop_act;
	logic [7:0]        rdata_q;
	logic [7:0]        rd_mux;
	logic              chain_reload_irq_q;

	// command ports decode on address alone
	wire mclr      = wr_i & (addr_i == OFS_MCLR);
	wire clr_bp    = wr_i & (addr_i == OFS_CLR_BP);
	wire clr_m_lo  = wr_i & (addr_i == OFS_CLR_MASK_LO);
	wire clr_m_hi  = wr_i & (addr_i == OFS_CLR_MASK_HI);
	wire clr_tcirq = wr_i & (addr_i == OFS_CLR_TCIRQ);
	wire chreg     = (addr_i >= OFS_BCNT0) & (addr_i <= OFS_RADR2);
	wire chreg_wr  = wr_i & chreg;
	wire rd_status = rd_i & (addr_i == OFS_STATUS);

	// polarity, group enables from command registers
	assign req_act = req_s_q ^ {NUM_CH{cmd2_q[CMD2_REQ_LOW_BIT]}};
	assign eop_act = eop_s_q ^ cmd2_q[CMD2_EOP_LOW_BIT];
	assign grp_en  = {{4{cmd1_q[CMD1_GRP1_EN_BIT]}}, {4{cmd1_q[CMD1_GRP0_EN_BIT]}}};

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cmd1_q   <= CMD1_RST;
			cmd2_q   <= CMD2_RST;
			chsel_q  <= CHSEL_RST;
			bp_q     <= 1'b0;
			tc_irq_q <= 1'b0;
		end
		else if (mclr)
		begin
			cmd1_q   <= CMD1_RST;
			cmd2_q   <= CMD2_RST;
			chsel_q  <= CHSEL_RST;
			bp_q     <= 1'b0;
			tc_irq_q <= 1'b0;
		end
		else
		begin
			if (wr_i && addr_i == OFS_CMD1)
				cmd1_q <= wdata_i;
			if (wr_i && addr_i == OFS_CMD2)
				cmd2_q <= wdata_i;
			if (wr_i && addr_i == OFS_CHSEL)
				chsel_q <= wdata_i[2:0];
			// third target byte leaves the pointer alone
			if (clr_bp)
				bp_q <= 1'b0;
			else if (chreg_wr && addr_i != OFS_TADR2)
				bp_q <= ~bp_q;
			// software-started buffer end wins over the clear command
			if (|swdone_v)
				tc_irq_q <= 1'b1;
			else if (clr_tcirq)
				tc_irq_q <= 1'b0;
		end
	end

	// ======================================================
	// arbitration
	dbc_arbiter #(
		.N (NUM_CH)
	) u_arb (
		.clk_i    (clk_i),
		.rst_ni   (rst_n),
		.req_i    (elig),
		.rotate_i (cmd1_q[CMD1_ROTATE_BIT]),
		.grant_o  (grant_d)
	);

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			grant_q            <= '0;
			chain_reload_irq_q <= 1'b0;
		end
		else
		begin
			grant_q            <= mclr ? '0 : grant_d;
			chain_reload_irq_q <= |pend_v;
		end
	end

	// ======================================================
	// per-channel state
	logic [7:0]  mode1_q    [NUM_CH];
	logic [7:0]  mode2_q    [NUM_CH];
	logic [23:0] base_cnt_q [NUM_CH];
	logic [31:0] base_tgt_q [NUM_CH];
	logic [23:0] base_req_q [NUM_CH];
	logic [23:0] cur_cnt_q  [NUM_CH];
	logic [31:0] cur_tgt_q  [NUM_CH];
	logic [23:0] cur_req_q  [NUM_CH];

	for (genvar i = 0; i < NUM_CH; i++)
	begin : g_ch
		logic        mask_q;
		logic        swreq_q;
		logic        chain_en_q;
		logic        pend_q;
		logic        tc_q;
		logic        run_q;
		logic        served_q;
		logic [23:0] bc_d;
		logic [31:0] bt_d;
		logic [23:0] br_d;

		wire        hit      = (chsel_q == 3'(i));
		wire        base_wr  = hit & chreg_wr;
		wire [1:0]  xmode    = mode1_q[i][MODE1_XFER_HI_BIT:MODE1_XFER_LO_BIT];
		// both mode bits high selects cascade
		wire        cascade  = (xmode == DBC_CASCADE);
		wire        autoinit = mode1_q[i][MODE1_AUTOINIT_BIT] & ~cascade;
		wire        single   = (xmode == DBC_SINGLE);
		wire        step     = grant_q[i] & ~cascade;
		wire        done     = step & ((cur_cnt_q[i] == 24'h0) | eop_act);
		// chain continues only once base was reloaded
		wire        chain_ok = chain_en_q & ~pend_q;
		wire        reload   = done & (autoinit | chain_ok);
		wire        chain_wr = hit & wr_i & (addr_i == OFS_CHAIN);
		wire        sel_wr   = wdata_i[2:0] == 3'(i);

		// unmasked channel, hardware or software start; cascade takes hardware start only
		// single needs a fresh request, block runs on
		assign elig[i] = ~mask_q & grp_en[i] & ~done &
			(cascade ? req_act[i] :
			 ((req_act[i] | swreq_q | run_q) & ~(single & (served_q | grant_q[i]))));
		assign done_v[i]   = done;
		assign swdone_v[i] = done & swreq_q;
		assign mask_v[i]   = mask_q;
		assign swreq_v[i]  = swreq_q;
		assign pend_v[i]   = pend_q;
		assign tc_v[i]     = tc_q;

		// byte merge of a base write
		always_comb
		begin
			bc_d = base_cnt_q[i];
			bt_d = base_tgt_q[i];
			br_d = base_req_q[i];
			unique case (addr_i)
				OFS_BCNT0: bc_d = {8'h00, bc_d[15:8], wdata_i};
				OFS_BCNT1: bc_d[15:8]  = wdata_i;
				OFS_BCNT2: bc_d[23:16] = wdata_i;
				OFS_TADR0: bt_d[7:0]   = wdata_i;
				OFS_TADR1: bt_d[15:8]  = wdata_i;
				OFS_TADR2: bt_d[23:16] = wdata_i;
				OFS_TADR3: bt_d[31:24] = wdata_i;
				OFS_RADR0: br_d[7:0]   = wdata_i;
				OFS_RADR1: br_d[15:8]  = wdata_i;
				OFS_RADR2: br_d[23:16] = wdata_i;
				default: ;
			endcase
		end

		always_ff @(posedge clk_i or negedge rst_n)
		begin
			if (!rst_n)
			begin
				base_cnt_q[i] <= '0;
				base_tgt_q[i] <= '0;
				base_req_q[i] <= '0;
				cur_cnt_q[i]  <= '0;
				cur_tgt_q[i]  <= '0;
				cur_req_q[i]  <= '0;
			end
			else
			begin
				if (base_wr)
				begin
					base_cnt_q[i] <= bc_d;
					base_tgt_q[i] <= bt_d;
					base_req_q[i] <= br_d;
				end
				if (step)
				begin
					cur_cnt_q[i] <= cur_cnt_q[i] - 24'h1;
					cur_tgt_q[i] <= mode1_q[i][MODE1_TGT_DEC_BIT] ?
						cur_tgt_q[i] - 32'h1 : cur_tgt_q[i] + 32'h1;
					if (!mode2_q[i][MODE2_REQ_HOLD_BIT])
						cur_req_q[i] <= cur_req_q[i] + 24'h1;
				end
				// reload at buffer end copies base to current
				if (reload)
				begin
					cur_cnt_q[i] <= base_cnt_q[i];
					cur_tgt_q[i] <= base_tgt_q[i];
					cur_req_q[i] <= base_req_q[i];
				end
				if (base_wr && !chain_en_q)
				begin
					cur_cnt_q[i] <= bc_d;
					cur_tgt_q[i] <= bt_d;
					cur_req_q[i] <= br_d;
				end
			end
		end

		always_ff @(posedge clk_i or negedge rst_n)
		begin
			if (!rst_n)
			begin
				mode1_q[i] <= MODE1_RST;
				mode2_q[i] <= MODE2_RST;
			end
			else if (mclr)
			begin
				mode1_q[i] <= MODE1_RST;
				mode2_q[i] <= MODE2_RST;
			end
			else
			begin
				if (hit && wr_i && addr_i == OFS_MODE1)
					mode1_q[i] <= wdata_i;
				if (hit && wr_i && addr_i == OFS_MODE2)
					mode2_q[i] <= wdata_i;
			end
		end

		always_ff @(posedge clk_i or negedge rst_n)
		begin
			if (!rst_n)
			begin
				mask_q     <= 1'b1;
				chain_en_q <= 1'b0;
				pend_q     <= 1'b0;
				swreq_q    <= 1'b0;
				tc_q       <= 1'b0;
				run_q      <= 1'b0;
				served_q   <= 1'b0;
			end
			else if (mclr)
			begin
				mask_q     <= 1'b1;
				chain_en_q <= 1'b0;
				pend_q     <= 1'b0;
				swreq_q    <= 1'b0;
				tc_q       <= 1'b0;
				run_q      <= 1'b0;
				served_q   <= 1'b0;
			end
			else
			begin
				// mask suspends, chain mode kept; end without reload masks
				if (done && !reload)
					mask_q <= 1'b1;
				else if (wr_i && addr_i == OFS_MASK_ONE && sel_wr)
					mask_q <= wdata_i[SEL_SET_BIT];
				else if (wr_i && addr_i == OFS_MASK_ALL)
					mask_q <= wdata_i[i];
				else if ((clr_m_lo && i < 4) || (clr_m_hi && i >= 4))
					mask_q <= 1'b0;
				if (done)
					swreq_q <= 1'b0;
				else if (wr_i && addr_i == OFS_SWREQ && sel_wr)
					swreq_q <= wdata_i[SEL_SET_BIT];
				if (chain_wr)
					chain_en_q <= wdata_i[CHAIN_EN_BIT];
				if (chain_wr && !wdata_i[CHAIN_EN_BIT])
					pend_q <= 1'b0;
				else if (chain_wr && !chain_en_q)
					pend_q <= 1'b1;
				else if (reload && chain_en_q)
					pend_q <= 1'b1;
				else if (base_wr && addr_i == OFS_TADR3)
					pend_q <= 1'b0;
				// set wins over the status read
				if (done)
					tc_q <= 1'b1;
				else if (rd_status)
					tc_q <= 1'b0;
				run_q    <= (step & (xmode == DBC_BLOCK) & ~done) | (run_q & ~done & ~mask_q);
				served_q <= (served_q | step) & req_act[i];
			end
		end
	end

	// ======================================================
	// read port, data one cycle after the strobe
	always_comb
	begin
		rd_mux = 8'h00;
		unique case (addr_i)
			OFS_CMD1:    rd_mux = cmd1_q;
			OFS_CMD2:    rd_mux = cmd2_q;
			OFS_CHSEL:   rd_mux = {5'h00, chsel_q};
			OFS_MODE1:   rd_mux = mode1_q[chsel_q];
			OFS_MODE2:   rd_mux = mode2_q[chsel_q];
			OFS_CHAIN:   rd_mux = pend_v;
			OFS_MASK_ALL: rd_mux = mask_v;
			OFS_SWREQ:   rd_mux = swreq_v;
			OFS_STATUS:  rd_mux = tc_v;
			OFS_REQSTAT: rd_mux = req_act;
			OFS_MISC:    rd_mux = {6'h00, tc_irq_q, bp_q};
			OFS_BCNT0:   rd_mux = cur_cnt_q[chsel_q][7:0];
			OFS_BCNT1:   rd_mux = cur_cnt_q[chsel_q][15:8];
			OFS_BCNT2:   rd_mux = cur_cnt_q[chsel_q][23:16];
			OFS_TADR0:   rd_mux = cur_tgt_q[chsel_q][7:0];
			OFS_TADR1:   rd_mux = cur_tgt_q[chsel_q][15:8];
			OFS_TADR2:   rd_mux = cur_tgt_q[chsel_q][23:16];
			OFS_TADR3:   rd_mux = cur_tgt_q[chsel_q][31:24];
			OFS_RADR0:   rd_mux = cur_req_q[chsel_q][7:0];
			OFS_RADR1:   rd_mux = cur_req_q[chsel_q][15:8];
			OFS_RADR2:   rd_mux = cur_req_q[chsel_q][23:16];
			default:     rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
			rdata_q <= 8'h00;
		else
			rdata_q <= rd_i ? rd_mux : 8'h00;
	end

	assign rdata_o            = rdata_q;
	assign grant_o            = grant_q;
	assign chain_reload_irq_o = chain_reload_irq_q;
	assign tc_irq_o           = tc_irq_q;

endmodule // dbc_ctrl

`default_nettype wire

// file: hw/dbc_pkg.sv
// package for the dma buffer-process control block
// assumes an 8-bit register port and eight channels
package dbc_pkg;

	localparam int NUM_CH = 8;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// ======================================================
	// register offsets
	localparam logic [7:0] OFS_CMD1        = 8'h00;
	localparam logic [7:0] OFS_CMD2        = 8'h01;
	localparam logic [7:0] OFS_CHSEL       = 8'h02;
	localparam logic [7:0] OFS_MODE1       = 8'h03;
	localparam logic [7:0] OFS_MODE2       = 8'h04;
	localparam logic [7:0] OFS_CHAIN       = 8'h05;
	localparam logic [7:0] OFS_MASK_ONE    = 8'h06;
	localparam logic [7:0] OFS_MASK_ALL    = 8'h07;
	localparam logic [7:0] OFS_SWREQ       = 8'h08;
	localparam logic [7:0] OFS_STATUS      = 8'h09;
	localparam logic [7:0] OFS_REQSTAT     = 8'h0a;
	localparam logic [7:0] OFS_MISC        = 8'h0b;
	localparam logic [7:0] OFS_BCNT0       = 8'h10;
	localparam logic [7:0] OFS_BCNT1       = 8'h11;
	localparam logic [7:0] OFS_BCNT2       = 8'h12;
	localparam logic [7:0] OFS_TADR0       = 8'h13;
	localparam logic [7:0] OFS_TADR1       = 8'h14;
	localparam logic [7:0] OFS_TADR2       = 8'h15;
	localparam logic [7:0] OFS_TADR3       = 8'h16;
	localparam logic [7:0] OFS_RADR0       = 8'h17;
	localparam logic [7:0] OFS_RADR1       = 8'h18;
	localparam logic [7:0] OFS_RADR2       = 8'h19;
	localparam logic [7:0] OFS_CLR_BP      = 8'h20;
	localparam logic [7:0] OFS_MCLR        = 8'h21;
	localparam logic [7:0] OFS_CLR_MASK_LO = 8'h22;
	localparam logic [7:0] OFS_CLR_MASK_HI = 8'h23;
	localparam logic [7:0] OFS_CLR_TCIRQ   = 8'h24;

	// ======================================================
	// field positions
	localparam int CMD1_GRP0_EN_BIT   = 0;
	localparam int CMD1_GRP1_EN_BIT   = 1;
	localparam int CMD1_ROTATE_BIT    = 2;
	localparam int CMD2_REQ_LOW_BIT   = 0;
	localparam int CMD2_EOP_LOW_BIT   = 1;
	localparam int MODE1_AUTOINIT_BIT = 4;
	localparam int MODE1_TGT_DEC_BIT  = 5;
	localparam int MODE1_XFER_LO_BIT  = 6;
	localparam int MODE1_XFER_HI_BIT  = 7;
	localparam int MODE2_REQ_HOLD_BIT = 0;
	localparam int CHAIN_EN_BIT       = 0;
	localparam int SEL_SET_BIT        = 3;
	localparam int MISC_BP_BIT        = 0;
	localparam int MISC_TCIRQ_BIT     = 1;

	// ======================================================
	// reset values
	localparam logic [7:0] CMD1_RST  = 8'h03;
	localparam logic [7:0] CMD2_RST  = 8'h00;
	localparam logic [7:0] MODE1_RST = 8'h00;
	localparam logic [7:0] MODE2_RST = 8'h00;
	localparam logic [2:0] CHSEL_RST = 3'h0;

	typedef enum logic [1:0] {
		DBC_DEMAND  = 2'h0,
		DBC_SINGLE  = 2'h1,
		DBC_BLOCK   = 2'h2,
		DBC_CASCADE = 2'h3
	} dbc_xfer_t;

endpackage

// file: tb/dbc_ctrl_asserts.sv
// port-level assertion checker for the buffer-process control block
// assumes one clock domain; bound onto dbc_ctrl at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module dbc_ctrl_asserts
	import dbc_pkg::*;
(
	input wire logic                       clk_i,
	input wire logic                       resetn_i,
	input wire logic [dbc_pkg::ADDR_W-1:0] addr_i,
	input wire logic [dbc_pkg::DATA_W-1:0] wdata_i,
	input wire logic                       wr_i,
	input wire logic                       rd_i,
	input wire logic [dbc_pkg::DATA_W-1:0] rdata_o,
	input wire logic [dbc_pkg::NUM_CH-1:0] channel_request_line_i,
	input wire logic                       end_of_process_input_i,
	input wire logic [dbc_pkg::NUM_CH-1:0] grant_o,
	input wire logic                       chain_reload_irq_o,
	input wire logic                       tc_irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	// ==========
	// host write events
	sequence s_chain_on;
		wr_i && addr_i == OFS_CHAIN && wdata_i[CHAIN_EN_BIT];
	endsequence
	sequence s_chain_off;
		wr_i && addr_i == OFS_CHAIN && !wdata_i[CHAIN_EN_BIT] && grant_o == '0;
	endsequence
	sequence s_hidden_wr;
		wr_i && addr_i == OFS_TADR3 && grant_o == '0;
	endsequence
	sequence s_all_masked;
		wr_i && addr_i == OFS_MASK_ALL && wdata_i == 8'hff;
	endsequence

	// ==========
	// checks
	AST_RD_IDLE: assert property (!rd_i |=> rdata_o == '0)
		else $error("read data not zero outside a read answer");
	AST_GRANT_ONE: assert property ($onehot0(grant_o))
		else $error("more than one channel granted");
	AST_RST_QUIET: assert property ($rose(resetn_i) |-> grant_o == '0 ##1 (grant_o == '0 && !chain_reload_irq_o))
		else $error("activity right after reset release");
	AST_CHAIN_SET: assert property (s_chain_on |-> ##2 chain_reload_irq_o)
		else $error("chain enable did not raise reload irq");
	AST_HIDDEN_CLR: assert property (s_hidden_wr |-> ##2 !chain_reload_irq_o)
		else $error("hidden target byte write left irq up");
	AST_CHAIN_OFF: assert property (s_chain_off |-> ##2 !chain_reload_irq_o)
		else $error("chain disable left irq up");
	AST_MASK_STOP: assert property (s_all_masked |-> ##2 (grant_o == '0) [*2])
		else $error("grant after all channels masked");
	AST_TC_CLR: assert property (wr_i && addr_i == OFS_CLR_TCIRQ |-> ##[1:2] !tc_irq_o)
		else $error("tc irq not cleared by its command port");
	AST_IRQ_CAUSE: assert property ($rose(chain_reload_irq_o) |->
		$past(wr_i, 2) || ($past(grant_o, 1) != '0) || ($past(grant_o, 2) != '0))
		else $error("reload irq rose without write or buffer end");
endmodule // dbc_ctrl_asserts

bind dbc_ctrl dbc_ctrl_asserts u_asserts (
	.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.channel_request_line_i(channel_request_line_i),
	.end_of_process_input_i(end_of_process_input_i), .grant_o(grant_o),
	.chain_reload_irq_o(chain_reload_irq_o), .tc_irq_o(tc_irq_o)
);
`default_nettype wire

// file: tb/dbc_ctrl_tb.sv
// self-checking bench for the buffer-process control block
// assumes the checker is bound in by its own file
`timescale 1ns/1ps
`default_nettype none
module dbc_ctrl_tb;
	import dbc_pkg::*;
	logic       clk_i      = 1'b0;
	logic       resetn_i   = 1'b0;
	logic [7:0] addr_i     = 8'h00;
	logic [7:0] wdata_i    = 8'h00;
	logic       wr_i       = 1'b0;
	logic       rd_i       = 1'b0;
	logic       rd_q       = 1'b0;
	logic [7:0] want       = 8'h00;
	logic       end_cmd    = 1'b0;
	logic       req_low    = 1'b0;
	logic [7:0] r;
	wire  [7:0] rdata_o;
	wire  [7:0] grant_o;
	wire  [7:0] req;
	wire        eop;
	wire        chain_reload_irq_o;
	wire        tc_irq_o;
	logic [7:0] expq[$];
	logic [7:0] mskq[$];
	int         gcnt[8]    = '{default: 0};
	int         g;
	int         fail_count = 0;
	int         checks     = 0;
	int         seed       = 32'h3acda91d;

	always #20 clk_i = ~clk_i;

	dbc_ctrl dut (
		.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.channel_request_line_i(req), .end_of_process_input_i(eop),
		.grant_o(grant_o), .chain_reload_irq_o(chain_reload_irq_o), .tc_irq_o(tc_irq_o)
	);
	dbc_periph_model u_periph (
		.clk_i(clk_i), .want_i(want), .end_i(end_cmd), .req_low_i(req_low),
		.end_low_i(1'b0), .req_o(req), .end_o(eop)
	);

	// ==========
	// helpers
	function automatic void cmp(input logic [7:0] gv, input logic [7:0] ev,
		input logic [7:0] m = 8'hff);
		checks++;
		if ((gv & m) !== (ev & m))
		begin
			fail_count++;
			$display("BAD %0t got %h want %h", $time, gv, ev);
		end
	endfunction
	task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic w);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= w;
		rd_i    <= !w;
		@(posedge clk_i);
		wr_i <= 1'b0;
		rd_i <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(a, d, 1'b1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		expq.push_back(e);
		mskq.push_back(8'hff);
		bus(a, 8'h00, 1'b0);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
		@(negedge clk_i);
	endtask
	task automatic wait_grant(input int ch);
		int n;
		n = 0;
		while (grant_o[ch] !== 1'b1 && n < 40)
		begin
			@(negedge clk_i);
			n++;
		end
		cmp(grant_o[ch], 1'b1);
	endtask
	task automatic finish_test();
		if (fail_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ==========
	// read answer monitor and grant counters
	always @(posedge clk_i)
	begin
		rd_q <= rd_i;
		if (rd_q)
			cmp(rdata_o, expq.pop_front(), mskq.pop_front());
		for (int i = 0; i < 8; i++)
			if (grant_o[i] === 1'b1)
				gcnt[i]++;
	end

	initial
	begin
		#100000;
		fail_count++;
		finish_test();
	end

	// ==========
	// main sequence
	initial
	begin
		repeat (3) @(posedge clk_i);
		resetn_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		r = 8'($random(seed));
		rd(OFS_MASK_ALL, 8'hff);
		rd(OFS_CHAIN, 8'h00);
		rd(OFS_CMD1, CMD1_RST);
		rd(OFS_CMD2, CMD2_RST);
		wr(8'h3f, r);
		rd(8'h3f, 8'h00);
		wr(OFS_CHSEL, 8'h02);
		wr(OFS_TADR0, r);
		rd(OFS_TADR0, r);
		wr(OFS_BCNT2, r | 8'h01);
		wr(OFS_BCNT0, r);
		rd(OFS_BCNT2, 8'h00);
		for (int m = 0; m < 4; m++)
		begin
			wr(OFS_MODE1, {2'(m), 6'h00});
			rd(OFS_MODE1, {2'(m), 6'h00});
		end
		wr(OFS_MODE1, MODE1_RST);
		wr(OFS_MASK_ONE, 8'h02);
		rd(OFS_MASK_ALL, 8'hfb);
		wr(OFS_CLR_MASK_HI, r);
		rd(OFS_MASK_ALL, 8'h0b);
		wr(OFS_MASK_ALL, 8'hff);
		// count rewritten before each start
		wr(OFS_CHSEL, 8'h00);
		wr(OFS_BCNT0, 8'h02);
		wr(OFS_MASK_ONE, 8'h00);
		g = gcnt[0];
		want[0] <= 1'b1;
		wait_grant(0);
		idle(8);
		cmp(8'(gcnt[0] - g), 8'h03);
		@(posedge clk_i);
		want[0] <= 1'b0;
		rd(OFS_MASK_ALL, 8'hff);
		rd(OFS_STATUS, 8'h01);
		rd(OFS_STATUS, 8'h00);
		wr(OFS_CHSEL, 8'h01);
		wr(OFS_MODE1, 8'h10);
		wr(OFS_BCNT0, 8'h40);
		wr(OFS_MASK_ONE, 8'h01);
		want[1] <= 1'b1;
		wait_grant(1);
		@(posedge clk_i);
		end_cmd <= 1'b1;
		repeat (4) @(posedge clk_i);
		end_cmd <= 1'b0;
		want[1] <= 1'b0;
		idle(6);
		rd(OFS_MASK_ALL, 8'hfd);
		rd(OFS_STATUS, 8'h02);
		rd(OFS_MODE1, 8'h10);
		wr(OFS_MASK_ONE, 8'h09);
		// chaining on a channel with reload clear
		wr(OFS_CHSEL, 8'h03);
		wr(OFS_BCNT0, 8'h00);
		wr(OFS_CHAIN, 8'h01);
		idle(2);
		cmp(chain_reload_irq_o, 1'b1);
		rd(OFS_CHAIN, 8'h08);
		wr(OFS_TADR3, r);
		idle(2);
		cmp(chain_reload_irq_o, 1'b0);
		wr(OFS_CHAIN, 8'h00);
		wr(OFS_CHAIN, 8'h01);
		wr(OFS_CHAIN, 8'h00);
		idle(2);
		cmp(chain_reload_irq_o, 1'b0);
		wr(OFS_CHAIN, 8'h01);
		wr(OFS_TADR3, r);
		wr(OFS_MASK_ONE, 8'h03);
		g = gcnt[3];
		want[3] <= 1'b1;
		wait_grant(3);
		idle(10);
		cmp(8'(gcnt[3] - g), 8'h02);
		cmp(chain_reload_irq_o, 1'b1);
		@(posedge clk_i);
		want[3] <= 1'b0;
		rd(OFS_MASK_ALL, 8'hff);
		rd(OFS_CHAIN, 8'h08);
		wr(OFS_CHAIN, 8'h00);
		// cascade channel loads no buffer
		wr(OFS_CHSEL, 8'h04);
		wr(OFS_MODE1, 8'hc0);
		wr(OFS_CLR_MASK_HI, r);
		want[4] <= 1'b1;
		wait_grant(4);
		idle(12);
		cmp(grant_o, 8'h10);
		@(posedge clk_i);
		want[4] <= 1'b0;
		idle(6);
		cmp(grant_o, 8'h00);
		rd(OFS_STATUS, 8'h08);
		rd(OFS_MASK_ALL, 8'h0f);
		wr(OFS_CHSEL, 8'h05);
		wr(OFS_SWREQ, 8'h0d);
		wait_grant(5);
		idle(4);
		cmp(tc_irq_o, 1'b1);
		rd(OFS_STATUS, 8'h20);
		wr(OFS_CLR_TCIRQ, r);
		idle(1);
		cmp(tc_irq_o, 1'b0);
		// single: one transfer per request
		wr(OFS_CHSEL, 8'h06);
		wr(OFS_MODE1, 8'h40);
		wr(OFS_BCNT0, 8'h02);
		g = gcnt[6];
		want[6] <= 1'b1;
		idle(10);
		cmp(8'(gcnt[6] - g), 8'h01);
		@(posedge clk_i);
		want[6] <= 1'b0;
		idle(6);
		@(posedge clk_i);
		want[6] <= 1'b1;
		idle(10);
		cmp(8'(gcnt[6] - g), 8'h02);
		@(posedge clk_i);
		want[6] <= 1'b0;
		// block: a short request runs the whole buffer
		wr(OFS_CHSEL, 8'h07);
		wr(OFS_MODE1, 8'h80);
		wr(OFS_BCNT0, 8'h03);
		g = gcnt[7];
		want[7] <= 1'b1;
		@(posedge clk_i);
		want[7] <= 1'b0;
		idle(16);
		cmp(8'(gcnt[7] - g), 8'h04);
		wr(OFS_MCLR, r);
		idle(1);
		rd(OFS_MASK_ALL, 8'hff);
		rd(OFS_CHAIN, 8'h00);
		// active-low request sampling
		wr(OFS_CMD2, 8'h01);
		req_low <= 1'b1;
		want[2] <= 1'b1;
		idle(4);
		rd(OFS_REQSTAT, 8'h04);
		idle(2);
		finish_test();
	end
endmodule // dbc_ctrl_tb
`default_nettype wire

// file: tb/dbc_periph_model.sv
// requesting peripheral: request lines and end-of-process line
// assumes the bench commands it; lines change only after a rising edge
`timescale 1ns/1ps
`default_nettype none
module dbc_periph_model (
	input  wire logic       clk_i,
	input  wire logic [7:0] want_i,
	input  wire logic       end_i,
	input  wire logic       req_low_i,
	input  wire logic       end_low_i,
	output logic      [7:0] req_o,
	output logic            end_o
);
	logic [7:0] req_q = 8'h00;
	logic       end_q = 1'b0;

	// ==========
	// lines drive the active level only while asked
	always @(posedge clk_i)
	begin
		req_q <= want_i ^ {8{req_low_i}};
		end_q <= end_i ^ end_low_i;
	end
	assign req_o = req_q;
	assign end_o = end_q;
endmodule // dbc_periph_model
`default_nettype wire
